// [logic/seq_ctrl_pkg.sv]
package seq_ctrl_pkg;
  localparam logic [3:0] OFS_SEQ_CTRL = 4'h0;
  localparam logic [3:0] OFS_CFG = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // control byte fields
  localparam int BIT_RJUST = 7;
  localparam int BIT_SIGNED = 6;
  localparam int BIT_SCAN = 5;
  localparam int BIT_MANY = 4;
  localparam int SEL_LSB = 0;
  // configuration word fields
  localparam int CFG_RES8 = 0;
  localparam int CFG_ETRIG = 1;
  localparam int CFG_WRAP_LSB = 4;
  localparam int CFG_LEN_LSB = 8;
  // status word fields
  localparam int ST_BUSY = 0;
  localparam int ST_CMPL = 1;
  localparam int ST_ARMED = 2;
  localparam int ST_CNT_LSB = 4;
  localparam int ST_CH_LSB = 8;
  localparam logic [7:0] RST_SEQ_CTRL = 8'h00;
  localparam logic [3:0] RST_WRAP = 4'hF;
  localparam logic [3:0] RST_LEN = 4'h4;
  localparam logic [3:0] RST_CNT = 4'h0;
  localparam logic [3:0] RST_CH = 4'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  typedef enum logic [1:0] {S_IDLE, S_ARMED, S_CONV} seq_e;

  typedef struct packed {
    logic [7:0] ctrl;
    logic res8;
    logic etrig;
    logic [3:0] wrap;
    logic [3:0] len;
    seq_e st;
    logic [3:0] cnt;
    logic [3:0] ch;
    logic start;
    logic [15:0] word;
    logic valid;
    logic cmpl;
    logic ack;
    logic [31:0] rdata;
    logic [2:0] trig_sync;
    logic trig_lvl;
  } state_s;
endpackage : seq_ctrl_pkg

// [logic/adc_sequence_control.sv]
// Operation
// R1 - control write aborts, restarts fresh sequence
// R2 - external trigger: arm by write, trigger starts
// R3 - start pulse marks beginning of sampling
// R4 - bit 7 selects right justification
// R5 - bit 6 selects two's complement results
// R6 - right justified is always unsigned
// R7 - bit 5 selects continuous scan
// R8 - external trigger ignores scan, one sequence
// R9 - single mode converts select code only
// R10 - multi mode converts length channels from select
// R11 - increment, wrap to zero after limit
// R12 - start above limit wraps after fifteen
// R13 - select code maps directly to input
// R14 - 8-bit left result in bits 15:8
// R15 - 8-bit right result in bits 7:0
// R16 - 10-bit left result in bits 15:6
// R17 - 10-bit right result in bits 9:0
// R18 - signed left equals unsigned top bit inverted
// R19 - resolution bit: zero ten, one eight
// R20 - restart clears conversion counter
// R21 - control resets to zero, nothing started
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module adc_sequence_control (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [3:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic EXT_TRIG,
  input wire logic CONV_DONE,
  input wire logic [9:0] CONV_DATA,
  output logic SAMPLE_START,
  output logic [3:0] CHANNEL,
  output logic LOW_RES,
  output logic [15:0] RESULT_WORD,
  output logic RESULT_VALID,
  output logic [3:0] CONV_COUNT,
  output logic SEQ_BUSY
);
  import seq_ctrl_pkg::*;

  state_s cur_ff;
  state_s nxt_ff;
  logic acc;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_stat;
  logic trig_evt;
  logic last;
  logic done;
  logic [31:0] rd_val;

  // one wait cycle so read data comes from a flip-flop
  assign WAITREQUEST = (READ | WRITE) & ~cur_ff.ack;
  assign acc = cur_ff.ack & (READ | WRITE);
  assign wr_ctrl = acc & WRITE & (ADDRESS == OFS_SEQ_CTRL) & BYTEENABLE[0];
  assign wr_cfg = acc & WRITE & (ADDRESS == OFS_CFG);
  assign wr_stat = acc & WRITE & (ADDRESS == OFS_STATUS) & BYTEENABLE[0];
  // change counts once second and third stage agree
  assign trig_evt = (cur_ff.trig_sync[1] == cur_ff.trig_sync[2])
                    & cur_ff.trig_sync[2] & ~cur_ff.trig_lvl;
  // a done in the start cycle belongs to the conversion just dropped
  assign done = (cur_ff.st == S_CONV) & CONV_DONE & ~cur_ff.start; // R1
  // length code zero runs sixteen conversions
  assign last = ~cur_ff.ctrl[BIT_MANY]
                | (cur_ff.cnt == cur_ff.len - 4'h1); // R10

  function automatic logic [15:0] fmt(input logic [9:0] d,
                                      input logic res8,
                                      input logic rj,
                                      input logic sgn);
    logic [15:0] w;
    w = 16'h0000;
    if (rj) begin
      if (res8) begin
        w = {8'h00, d[7:0]}; // R15
      end else begin
        w = {6'h00, d}; // R17
      end
    end else begin
      if (res8) begin
        w = {d[7:0], 8'h00}; // R14
      end else begin
        w = {d, 6'h00}; // R16
      end
      // signed only exists left justified
      w[15] = w[15] ^ sgn; // R18 R6
    end
    return w;
  endfunction : fmt

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (ADDRESS)
      OFS_SEQ_CTRL: rd_val[7:0] = cur_ff.ctrl;
      OFS_CFG: begin
        rd_val[CFG_RES8] = cur_ff.res8;
        rd_val[CFG_ETRIG] = cur_ff.etrig;
        rd_val[CFG_WRAP_LSB +: 4] = cur_ff.wrap;
        rd_val[CFG_LEN_LSB +: 4] = cur_ff.len;
      end
      OFS_STATUS: begin
        rd_val[ST_BUSY] = cur_ff.st == S_CONV;
        rd_val[ST_CMPL] = cur_ff.cmpl;
        rd_val[ST_ARMED] = cur_ff.st == S_ARMED;
        rd_val[ST_CNT_LSB +: 4] = cur_ff.cnt;
        rd_val[ST_CH_LSB +: 4] = cur_ff.ch;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ack = (READ | WRITE) & ~cur_ff.ack;
    if ((READ | WRITE) & ~cur_ff.ack) begin
      nxt_ff.rdata = READ ? rd_val : 32'h0000_0000;
    end
    nxt_ff.trig_sync = {cur_ff.trig_sync[1:0], EXT_TRIG};
    if (cur_ff.trig_sync[1] == cur_ff.trig_sync[2]) begin
      nxt_ff.trig_lvl = cur_ff.trig_sync[2];
    end
    nxt_ff.start = 1'b0;
    nxt_ff.valid = 1'b0;
    if (wr_cfg) begin
      if (BYTEENABLE[0]) begin
        nxt_ff.res8 = WRITEDATA[CFG_RES8]; // R19
        nxt_ff.etrig = WRITEDATA[CFG_ETRIG];
        nxt_ff.wrap = WRITEDATA[CFG_WRAP_LSB +: 4];
      end
      if (BYTEENABLE[1]) begin
        nxt_ff.len = WRITEDATA[CFG_LEN_LSB +: 4];
      end
    end
    if (wr_stat & WRITEDATA[ST_CMPL]) begin
      nxt_ff.cmpl = 1'b0;
    end
    unique case (cur_ff.st)
      S_IDLE: begin
      end
      S_ARMED: begin
        if (trig_evt) begin
          nxt_ff.st = S_CONV; // R2 R8
          nxt_ff.start = 1'b1;
          nxt_ff.cnt = RST_CNT;
          nxt_ff.ch = cur_ff.ctrl[SEL_LSB +: 4];
        end
      end
      S_CONV: begin
        if (done) begin
          nxt_ff.valid = 1'b1;
          nxt_ff.word = fmt(CONV_DATA, cur_ff.res8,
                            cur_ff.ctrl[BIT_RJUST],
                            cur_ff.ctrl[BIT_SIGNED]); // R4 R5
          if (last) begin
            nxt_ff.cmpl = 1'b1;
            nxt_ff.cnt = RST_CNT;
            nxt_ff.ch = cur_ff.ctrl[SEL_LSB +: 4];
            if (cur_ff.etrig) begin
              nxt_ff.st = S_ARMED; // R8
            end else if (cur_ff.ctrl[BIT_SCAN]) begin
              nxt_ff.start = 1'b1; // R7
            end else begin
              nxt_ff.st = S_IDLE; // R7
            end
          end else begin
            nxt_ff.cnt = cur_ff.cnt + 4'h1;
            nxt_ff.start = 1'b1;
            if (!cur_ff.ctrl[BIT_MANY]) begin
              nxt_ff.ch = cur_ff.ctrl[SEL_LSB +: 4]; // R9
            end else if (cur_ff.ch == cur_ff.wrap) begin
              nxt_ff.ch = 4'h0; // R11
            end else begin
              // above the limit this rolls 15 to 0 by itself
              nxt_ff.ch = cur_ff.ch + 4'h1; // R11 R12
            end
          end
        end
      end
      default: nxt_ff.st = S_IDLE;
    endcase
    // a control write overrides the state, count, channel and start set above; a result from done still goes out
    if (wr_ctrl) begin
      nxt_ff.ctrl = WRITEDATA[7:0];
      nxt_ff.cnt = RST_CNT; // R20
      nxt_ff.ch = WRITEDATA[SEL_LSB +: 4]; // R13
      nxt_ff.cmpl = 1'b0;
      if (cur_ff.etrig) begin
        nxt_ff.st = S_ARMED; // R2
        nxt_ff.start = 1'b0;
      end else begin
        nxt_ff.st = S_CONV; // R1
        nxt_ff.start = 1'b1; // R3
      end
    end
    // set wins over a status-register clear in the same cycle; a control write clears it even then
    if (done & last) begin
      nxt_ff.cmpl = ~wr_ctrl;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cur_ff <= '{ctrl: RST_SEQ_CTRL, res8: 1'b0, etrig: 1'b0,
                  wrap: RST_WRAP, len: RST_LEN, st: S_IDLE,
                  cnt: RST_CNT, ch: RST_CH, start: 1'b0,
                  word: RST_WORD, valid: 1'b0, cmpl: 1'b0,
                  ack: 1'b0, rdata: RST_RDATA, trig_sync: 3'h0,
                  trig_lvl: 1'b0}; // R21
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign READDATA = cur_ff.rdata;
  assign SAMPLE_START = cur_ff.start;
  assign CHANNEL = cur_ff.ch;
  assign LOW_RES = cur_ff.res8;
  assign RESULT_WORD = cur_ff.word;
  assign RESULT_VALID = cur_ff.valid;
  assign CONV_COUNT = cur_ff.cnt;
  assign SEQ_BUSY = cur_ff.st == S_CONV;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  AST_WRITE_RESTART: assert property ( // R1
    wr_ctrl & ~cur_ff.etrig |=> SAMPLE_START & SEQ_BUSY
      & CHANNEL == $past(WRITEDATA[3:0]))
    else $error("control write did not restart");
  AST_COUNT_CLEAR: assert property ( // R20
    wr_ctrl |=> CONV_COUNT == 4'h0)
    else $error("counter not cleared on write");
  AST_ARM: assert property ( // R2
    wr_ctrl & cur_ff.etrig |=> cur_ff.st == S_ARMED & ~SAMPLE_START)
    else $error("trigger mode write did not arm");
  AST_TRIG_GO: assert property ( // R2
    cur_ff.st == S_ARMED & trig_evt & ~wr_ctrl |=> SAMPLE_START)
    else $error("trigger did not start a sequence");
  AST_START_SAMPLE: assert property ( // R3
    SAMPLE_START |-> SEQ_BUSY)
    else $error("start pulse outside a sequence");
  AST_SINGLE_CH: assert property ( // R9
    SEQ_BUSY & ~cur_ff.ctrl[BIT_MANY] |-> CHANNEL == cur_ff.ctrl[3:0])
    else $error("single mode channel moved");
  AST_WRAP: assert property ( // R11
    done & ~last & cur_ff.ctrl[BIT_MANY] & CHANNEL == cur_ff.wrap
      & ~wr_ctrl |=> CHANNEL == 4'h0)
    else $error("no wrap to zero at limit");
  AST_RIGHT_UNSIGNED: assert property ( // R6
    done & cur_ff.ctrl[BIT_RJUST] |=> RESULT_VALID
      & RESULT_WORD[15:10] == 6'h00)
    else $error("right justified result has upper bits");
  AST_SIGNED_FLIP: assert property ( // R18
    done & ~cur_ff.ctrl[BIT_RJUST] & ~cur_ff.res8 |=>
      RESULT_WORD == {$past(CONV_DATA) ^ {$past(cur_ff.ctrl[6]),
      9'h000}, 6'h00})
    else $error("left justified format wrong");
  AST_ONCE: assert property ( // R7
    done & last & ~cur_ff.ctrl[BIT_SCAN] & ~cur_ff.etrig & ~wr_ctrl
      |=> ~SEQ_BUSY ##1 (~SEQ_BUSY | $past(wr_ctrl)))
    else $error("single sequence did not stop");
  AST_TRIG_ONE: assert property ( // R8
    done & last & cur_ff.etrig & ~wr_ctrl |=> cur_ff.st == S_ARMED)
    else $error("trigger mode repeated sequence");
  AST_LEFT8: assert property ( // R14
    done & ~cur_ff.ctrl[BIT_RJUST] & cur_ff.res8 |=> RESULT_WORD ==
      {$past(CONV_DATA[7:0]) ^ {$past(cur_ff.ctrl[BIT_SIGNED]), 7'h00},
      8'h00})
    else $error("eight bit left result misplaced");
  AST_RIGHT8: assert property ( // R15
    done & cur_ff.ctrl[BIT_RJUST] & cur_ff.res8 |=>
      RESULT_WORD == {8'h00, $past(CONV_DATA[7:0])})
    else $error("eight bit right result misplaced");
  AST_RIGHT10: assert property ( // R17
    done & cur_ff.ctrl[BIT_RJUST] & ~cur_ff.res8 |=>
      RESULT_WORD == {6'h00, $past(CONV_DATA)})
    else $error("ten bit right result misplaced");
  AST_LEFT10: assert property ( // R16
    done & ~cur_ff.ctrl[BIT_RJUST] & ~cur_ff.res8 |=> RESULT_WORD[5:0]
      == 6'h00 & RESULT_WORD[14:6] == $past(CONV_DATA[8:0]))
    else $error("ten bit left result misplaced");
  AST_SIGN_BIT: assert property ( // R5
    done & ~cur_ff.ctrl[BIT_RJUST] & cur_ff.res8
      & cur_ff.ctrl[BIT_SIGNED] |=> RESULT_WORD[15] != $past(CONV_DATA[7]))
    else $error("signed result top bit not inverted");
  AST_LOW_RES: assert property ( // R19
    wr_cfg & BYTEENABLE[0] |=> LOW_RES == $past(WRITEDATA[CFG_RES8]))
    else $error("resolution bit not taken");
  AST_SELECT: assert property ( // R13
    wr_ctrl |=> CHANNEL == $past(WRITEDATA[SEL_LSB +: 4]))
    else $error("select code not mapped to channel");
  AST_RESULT_PULSE: assert property ( // R4
    done |=> RESULT_VALID)
    else $error("finished conversion gave no result");
  AST_NEXT_START: assert property ( // R10
    done & ~last & ~wr_ctrl |=>
      SAMPLE_START & SEQ_BUSY)
    else $error("sequence stalled before its length");
  AST_COUNT_STEP: assert property ( // R10
    done & ~last & ~wr_ctrl |=>
      CONV_COUNT == $past(CONV_COUNT) + 4'h1)
    else $error("conversion counter did not step");
  AST_INCREMENT: assert property ( // R12
    done & ~last & cur_ff.ctrl[BIT_MANY] & CHANNEL != cur_ff.wrap
      & ~wr_ctrl |=> CHANNEL == $past(CHANNEL) + 4'h1)
    else $error("next channel not the increment");
  AST_END_COUNT: assert property ( // R20
    done & last |=> CONV_COUNT == 4'h0)
    else $error("counter not cleared at sequence end");
  AST_ARMED_QUIET: assert property ( // R2
    cur_ff.st == S_ARMED & ~trig_evt & ~wr_ctrl |=>
      ~SAMPLE_START & cur_ff.st == S_ARMED)
    else $error("armed state left without trigger");
  AST_SCAN_AGAIN: assert property ( // R7
    done & last & cur_ff.ctrl[BIT_SCAN] & ~cur_ff.etrig & ~wr_ctrl
      |=> SAMPLE_START & CHANNEL == cur_ff.ctrl[SEL_LSB +: 4])
    else $error("scan did not restart at select");
  AST_CMPL_SET: assert property ( // R7
    done & last & ~wr_ctrl |=> cur_ff.cmpl)
    else $error("complete flag not set");
  AST_IDLE_NO_RESULT: assert property ( // R8
    ~SEQ_BUSY |=> ~RESULT_VALID)
    else $error("result outside a sequence");
  AST_ABORT_DROP: assert property ( // R1
    SAMPLE_START & CONV_DONE |=> ~RESULT_VALID)
    else $error("stale conversion taken after start");

  COV_SCAN: cover property (done & last & cur_ff.ctrl[BIT_SCAN]);
  COV_WRAP: cover property (done & cur_ff.ctrl[BIT_MANY]
                            & CHANNEL == cur_ff.wrap);
  COV_TRIG: cover property (cur_ff.st == S_ARMED & trig_evt);
  COV_ABORT: cover property (SEQ_BUSY & wr_ctrl);
  COV_STALE: cover property (SAMPLE_START & CONV_DONE & SEQ_BUSY);
endmodule : adc_sequence_control
`default_nettype wire

// [testbench/conv_core_model.sv]
`timescale 1ns/1ns
`default_nettype none
module conv_core_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sample_start,
  input wire logic [3:0] delay,
  input wire logic [9:0] next_data,
  output logic conv_done,
  output logic [9:0] conv_data
);
  int cnt;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      conv_done <= 1'b0;
      conv_data <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      // code is only meaningful with the done pulse
      conv_data <= ~conv_data;
      if (sample_start) begin
        // a new start drops any conversion in flight
        cnt <= int'(delay) + 2;
      end else if (cnt == 1) begin
        conv_done <= 1'b1;
        conv_data <= next_data;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : conv_core_model
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import seq_ctrl_pkg::*;
  logic CLK = 0, ARST_N = 0, READ = 0, WRITE = 0, EXT_TRIG = 0;
  logic [3:0] ADDRESS = 4'h0, BYTEENABLE = 4'hF, dly = 4'h0;
  logic [31:0] WRITEDATA = 32'h0, READDATA, q;
  logic [9:0] CONV_DATA, nd = 10'h000;
  logic CONV_DONE, WAITREQUEST, SAMPLE_START, LOW_RES, RESULT_VALID, SEQ_BUSY;
  logic [3:0] CHANNEL, CONV_COUNT;
  logic [15:0] RESULT_WORD;
  logic [7:0] ctl = 8'h00;
  logic [11:0] cfg = 12'h4F0;
  logic wtake = 0;
  int bad_count = 0, checked = 0, rcnt = 0;
  int seed = 32'hD0A1BEA8;
  logic [3:0] chq[$];
  logic [15:0] rq[$];
  always #5 CLK = ~CLK;
  adc_sequence_control i_dut (.CLK(CLK), .ARST_N(ARST_N), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .EXT_TRIG(EXT_TRIG), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
    .SAMPLE_START(SAMPLE_START), .CHANNEL(CHANNEL), .LOW_RES(LOW_RES),
    .RESULT_WORD(RESULT_WORD), .RESULT_VALID(RESULT_VALID),
    .CONV_COUNT(CONV_COUNT), .SEQ_BUSY(SEQ_BUSY));
  conv_core_model i_core (.clk(CLK), .arst_n(ARST_N),
    .sample_start(SAMPLE_START), .delay(dly), .next_data(nd),
    .conv_done(CONV_DONE), .conv_data(CONV_DATA));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK);
    ADDRESS <= a;
    WRITE <= w;
    READ <= !w;
    WRITEDATA <= d;
    k = 0;
    do begin @(negedge CLK); k++; end while (WAITREQUEST !== 1'b0 && k < 20);
    if (k >= 20) begin bad_count++; results(); end
    // answer taken at the rising edge that samples waitrequest low
    @(posedge CLK);
    q = READDATA;
    if (w && a == OFS_SEQ_CTRL) begin wtake = 1; ctl = d[7:0]; end
    if (w && a == OFS_CFG) cfg = d[11:0];
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask : bus
  task automatic wait_lvl(input logic v);
    int k;
    k = 0;
    do begin @(negedge CLK); k++; end while (SEQ_BUSY !== v && k < 800);
    if (k >= 800) begin bad_count++; results(); end
    if (!v) chk("pending channels", 0, chq.size());
  endtask : wait_lvl
  function automatic int slen;
    if (!ctl[BIT_MANY]) return 1;
    return cfg[CFG_LEN_LSB +: 4] == 4'h0 ? 16 : int'(cfg[CFG_LEN_LSB +: 4]);
  endfunction : slen
  function automatic logic [15:0] fmt(input logic [9:0] d);
    logic sg;
    sg = ctl[BIT_SIGNED] && !ctl[BIT_RJUST];
    if (cfg[CFG_RES8]) return ctl[BIT_RJUST] ? {8'h00, d[7:0]}
      : {d[7] ^ sg, d[6:0], 8'h00};
    return ctl[BIT_RJUST] ? {6'h00, d} : {d[9] ^ sg, d[8:0], 6'h00};
  endfunction : fmt
  task automatic fill;
    logic [3:0] c;
    c = ctl[3:0];
    repeat (slen()) begin
      chq.push_back(c);
      c = (c == cfg[CFG_WRAP_LSB +: 4] || c == 4'hF) ? 4'h0 : c + 4'h1;
    end
  endtask : fill
  always @(posedge CLK) begin
    nd <= 10'($random(seed));
    dly <= 4'($random(seed));
  end
  // outputs settle after the launching edge, so look mid-cycle
  always @(negedge CLK) begin
    if (RESULT_VALID) begin
      chk("result word", rq.size() ? 32'(rq.pop_front()) : 32'hX,
          RESULT_WORD);
      rcnt = wtake ? 0 : (rcnt + 1) % slen();
      chk("conversion count", rcnt, CONV_COUNT);
    end
    // a control write restarts everything the model expects
    if (wtake) begin rq.delete(); chq.delete(); rcnt = 0; wtake = 0; end
    if (SAMPLE_START) begin
      if (chq.size() == 0) fill();
      chk("channel", chq.pop_front(), CHANNEL);
      chk("low res", cfg[CFG_RES8], LOW_RES);
    end
    // a done in the start cycle belongs to the dropped conversion
    if (CONV_DONE && SEQ_BUSY && !SAMPLE_START) rq.push_back(fmt(CONV_DATA));
  end
  initial begin
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
    bus(0, OFS_SEQ_CTRL, 0);
    chk("control after reset", 0, q);
    chk("busy after reset", 0, SEQ_BUSY);
    bus(0, 4'hC, 0);
    chk("unmapped read", 0, q);
    for (int i = 0; i < 16; i++) begin
      bus(1, OFS_CFG, {20'h0, 4'($random(seed)), 4'($random(seed)), 3'h0, i[0]});
      bus(1, OFS_SEQ_CTRL, {24'h0, i[1], i[2], 1'b0, i[3], 4'($random(seed))});
      bus(0, OFS_SEQ_CTRL, 0);
      chk("control readback", ctl, q);
      wait_lvl(0);
    end
    bus(1, OFS_CFG, 32'h2F0);
    bus(1, OFS_SEQ_CTRL, 32'h3E);
    repeat (100) @(posedge CLK);
    chk("scan keeps running", 1, SEQ_BUSY);
    bus(1, OFS_SEQ_CTRL, 32'h05);
    wait_lvl(0);
    bus(1, OFS_CFG, 32'h4F2);
    bus(1, OFS_SEQ_CTRL, 32'h33);
    repeat (30) @(posedge CLK);
    chk("armed waits for trigger", 0, SEQ_BUSY);
    repeat (2) begin
      EXT_TRIG <= 1'b1;
      repeat (3) @(posedge CLK);
      EXT_TRIG <= 1'b0;
      wait_lvl(1);
      wait_lvl(0);
      repeat (30) @(posedge CLK);
      chk("one sequence per trigger", 0, SEQ_BUSY);
    end
    results();
  end
endmodule : testbench
`default_nettype wire
